// ==== core/sav_top.sv ====
/*
 * Stream attribute and VM tag selector: per-transaction resolution of the
 * instruction/data attribute and the TLB VM tag from stream table entry
 * fields, with an AHB-Lite register slave for feature bits and status.
 * Assumes a single AHB-Lite master doing word transfers, and transaction
 * inputs synchronous to hclk.
 */
// Design decisions made here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module sav_top (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Incoming transaction
	input  wire logic        txn_valid,
	input  wire logic        txn_write,
	input  wire logic        txn_inst,
	input  wire logic [31:0] txn_entry_word,
	input  wire logic        txn_entry_secure,
	input  wire logic [1:0]  txn_world,
	input  wire logic [1:0]  txn_stage_en,
	// Resolved result
	output logic             out_valid,
	output logic             out_inst,
	output logic             out_tag_en,
	output logic [15:0]      out_tag,
	output logic             out_tag_secure,
	output logic [11:0]      out_impl_cfg,
	output logic             out_illegal
);

	// Register state
	logic [4:0]  feature;       // Feature bits set by software
	logic        illegal_seen;  // Sticky illegal tag flag
	logic [15:0] txn_count;     // Wrapping transaction count

	// Bus data phase state
	logic        dp_write;      // Pending write
	logic [7:0]  dp_addr;       // Pending write offset

	// Resolution results
	logic        res_inst;
	logic [15:0] eff_tag;
	logic        res_tag_en;
	logic [15:0] res_tag;
	logic        res_tag_sec;
	logic        res_illegal;

	// Address phase decode
	logic        ap_valid;
	logic [31:0] rd_value;

	// Offset match, used for reads and writes
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	assign ap_valid = hsel && htrans[1] && hready;

	// Attribute resolution
	sav_inst_attr u_attr (
		.attr_override_supported (feature[sav_pkg::FEAT_ATTR_OVR]),
		.txn_write               (txn_write),
		.txn_inst                (txn_inst),
		.inst_data_override      (txn_entry_word[sav_pkg::IDO_LSB +: 2]),
		.res_inst                (res_inst)
	);

	// Tag resolution
	sav_vm_tag u_tag (
		.stage2_present          (feature[sav_pkg::FEAT_S2_PRESENT]),
		.secure_stage2_present   (feature[sav_pkg::FEAT_SEC_S2]),
		.wide_vm_tag_support     (feature[sav_pkg::FEAT_WIDE_TAG]),
		.embedded_variant        (feature[sav_pkg::FEAT_EMBEDDED]),
		.entry_secure            (txn_entry_secure),
		.stream_privilege_world  (txn_world),
		.stage_en                (txn_stage_en),
		.stage2_vm_tag           (txn_entry_word[sav_pkg::TAG_LSB +: sav_pkg::TAG_WIDTH]),
		.eff_tag                 (eff_tag),
		.tag_en                  (res_tag_en),
		.tag                     (res_tag),
		.tag_secure              (res_tag_sec),
		.tag_illegal             (res_illegal)
	);

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_value = 32'h0000_0000;
		if (hit(haddr[7:0], sav_pkg::OFF_FEATURE)) begin
			rd_value[sav_pkg::FEAT_WIDTH-1:0] = feature;
		end else if (hit(haddr[7:0], sav_pkg::OFF_LAST)) begin
			rd_value[sav_pkg::LAST_TAG_LSB +: 16] = out_tag;
			rd_value[sav_pkg::LAST_TAG_EN]        = out_tag_en;
			rd_value[sav_pkg::LAST_TAG_SEC]       = out_tag_secure;
			rd_value[sav_pkg::LAST_INST]          = out_inst;
		end else if (hit(haddr[7:0], sav_pkg::OFF_ILLEGAL)) begin
			rd_value[0] = illegal_seen;
		end else if (hit(haddr[7:0], sav_pkg::OFF_COUNT)) begin
			rd_value[15:0] = txn_count;
		end
		// Offsets outside the low byte alias nothing
		if (haddr[31:8] != 24'h000000) begin
			rd_value = 32'h0000_0000;
		end
	end

	// Bus handshake: zero wait states, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Capture address phase; read data lands for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr  <= 8'h00;
			hrdata   <= 32'h0000_0000;
		end else begin
			dp_write <= ap_valid && hwrite && haddr[31:8] == 24'h000000;
			dp_addr  <= haddr[7:0];
			if (ap_valid && !hwrite) begin
				hrdata <= rd_value;
			end
		end
	end

	// Feature register; changes act on the next transaction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			feature <= sav_pkg::FEATURE_RESET;
		end else if (dp_write && hit(dp_addr, sav_pkg::OFF_FEATURE)) begin
			feature <= hwdata[sav_pkg::FEAT_WIDTH-1:0];
		end
	end

	// Sticky illegal flag; a new event beats a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			illegal_seen <= 1'b0;
		end else if (txn_valid && res_illegal) begin
			illegal_seen <= 1'b1;
		end else if (dp_write && hit(dp_addr, sav_pkg::OFF_ILLEGAL) && hwdata[0]) begin
			illegal_seen <= 1'b0;
		end
	end

	// Transaction counter, wraps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txn_count <= sav_pkg::COUNT_RESET;
		end else if (txn_valid) begin
			txn_count <= txn_count + 16'h0001;
		end
	end

	// Result stage: one registered cycle after the transaction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_valid      <= 1'b0;
			out_inst       <= 1'b0;
			out_tag_en     <= 1'b0;
			out_tag        <= 16'h0000;
			out_tag_secure <= 1'b0;
			out_impl_cfg   <= 12'h000;
			out_illegal    <= 1'b0;
		end else begin
			out_valid <= txn_valid;
			if (txn_valid) begin
				out_inst       <= res_inst;
				out_tag_en     <= res_tag_en;
				out_tag        <= res_tag;
				out_tag_secure <= res_tag_sec;
				out_impl_cfg   <= txn_entry_word[sav_pkg::IMPL_LSB +: sav_pkg::IMPL_WIDTH];
				out_illegal    <= res_illegal;
			end
		end
	end

	// Checks on the resolved outputs, the effective tag and the sticky illegal flag
	logic rd_in;   // Read transaction offered
	assign rd_in = txn_valid && !txn_write;

	a_ovr_data_forced:
	assert property (@(posedge hclk) disable iff (!hresetn)
		rd_in && feature[sav_pkg::FEAT_ATTR_OVR]
		&& txn_entry_word[sav_pkg::IDO_LSB +: 2] == 2'h2 |=> out_valid && !out_inst)
	else $error("data override not applied");

	a_ovr_inst_forced:
	assert property (@(posedge hclk) disable iff (!hresetn)
		rd_in && feature[sav_pkg::FEAT_ATTR_OVR]
		&& txn_entry_word[sav_pkg::IDO_LSB +: 2] == 2'h3 |=> out_inst)
	else $error("instruction override not applied");

	a_ovr_pass_through:
	assert property (@(posedge hclk) disable iff (!hresetn)
		rd_in && feature[sav_pkg::FEAT_ATTR_OVR]
		&& !txn_entry_word[sav_pkg::IDO_LSB + 1] |=> out_inst == $past(txn_inst))
	else $error("pass encodings changed attribute");

	a_no_ovr_support:
	assert property (@(posedge hclk) disable iff (!hresetn)
		rd_in && !feature[sav_pkg::FEAT_ATTR_OVR] |=> out_inst == $past(txn_inst))
	else $error("override used without support");

	a_write_is_data:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && txn_write |=> out_valid && !out_inst)
	else $error("write classified as instruction");

	a_impl_bits_out:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid
		|=> out_impl_cfg == $past(txn_entry_word[sav_pkg::IMPL_LSB +: sav_pkg::IMPL_WIDTH]))
	else $error("implementation bits not forwarded");

	a_ns_kernel_tag:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && !txn_entry_secure && feature[sav_pkg::FEAT_S2_PRESENT]
		&& txn_world == 2'b00 && txn_stage_en != 2'b00
		|=> out_tag_en && out_tag == $past(eff_tag) && !out_tag_secure)
	else $error("non-secure kernel tag wrong");

	a_sec_stage2_tag:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && txn_entry_secure && feature[sav_pkg::FEAT_SEC_S2]
		&& txn_world == 2'b10 && txn_stage_en[1]
		|=> out_tag_en && out_tag == $past(eff_tag) && out_tag_secure)
	else $error("secure stage 2 tag wrong");

	a_sec_s1_zero:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && txn_entry_secure && feature[sav_pkg::FEAT_SEC_S2]
		&& txn_world == 2'b10 && txn_stage_en == 2'b01
		|=> out_tag_en && out_tag == 16'h0000)
	else $error("secure stage 1 tag not zero");

	a_no_tag_cases:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && (txn_stage_en == 2'b00
		|| (!txn_entry_secure && (!feature[sav_pkg::FEAT_S2_PRESENT] || txn_world != 2'b00))
		|| (txn_entry_secure && (!feature[sav_pkg::FEAT_SEC_S2] || txn_world != 2'b10)))
		|=> !out_tag_en && out_tag == 16'h0000)
	else $error("tag applied where field is ignored");

	a_embed_raz:
	assert property (@(posedge hclk) disable iff (!hresetn)
		feature[sav_pkg::FEAT_EMBEDDED] && !feature[sav_pkg::FEAT_S2_PRESENT]
		|-> eff_tag == 16'h0000)
	else $error("embedded tag field not zero");

	a_embed_narrow:
	assert property (@(posedge hclk) disable iff (!hresetn)
		feature[sav_pkg::FEAT_EMBEDDED] && !feature[sav_pkg::FEAT_WIDE_TAG]
		|-> eff_tag[15:8] == 8'h00)
	else $error("embedded narrow tag top byte set");

	a_illegal_sticky:
	assert property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && res_illegal |=> illegal_seen)
	else $error("illegal tag not held");

	// Main scenarios
	c_nested_secure:
	cover property (@(posedge hclk) disable iff (!hresetn)
		txn_valid && txn_entry_secure && txn_stage_en == 2'b11 ##1 out_tag_en);
	c_inst_forced:
	cover property (@(posedge hclk) disable iff (!hresetn)
		rd_in && txn_entry_word[3:2] == 2'h3 ##1 out_inst);
	c_illegal_seen:
	cover property (@(posedge hclk) disable iff (!hresetn) txn_valid && res_illegal);

endmodule

`default_nettype wire

// ==== core/sav_pkg.sv ====
/*
 * Shared constants for the stream attribute and VM tag selector: register
 * offsets, feature bit positions, reset values, entry field positions and
 * world encodings.
 * Assumes a 32-bit AHB-Lite register bus and a word of the stream table
 * entry holding entry bits 143 down to 112.
 */
`default_nettype none

package sav_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_FEATURE = 8'h00;   // Feature bits, read/write
	localparam logic [7:0] OFF_LAST    = 8'h04;   // Last resolved result, read only
	localparam logic [7:0] OFF_ILLEGAL = 8'h08;   // Sticky illegal tag flag, write one to clear
	localparam logic [7:0] OFF_COUNT   = 8'h0c;   // Transactions resolved, read only

	// Feature register bit positions
	localparam int FEAT_ATTR_OVR   = 0;           // attr_override_supported
	localparam int FEAT_S2_PRESENT = 1;           // stage2_present
	localparam int FEAT_WIDE_TAG   = 2;           // wide_vm_tag_support
	localparam int FEAT_SEC_S2     = 3;           // secure_stage2_present
	localparam int FEAT_EMBEDDED   = 4;           // embedded_variant
	localparam int FEAT_WIDTH      = 5;
	localparam logic [4:0] FEATURE_RESET = 5'h00; // Nothing supported until software says so

	// Last-result register bit positions
	localparam int LAST_TAG_LSB  = 0;
	localparam int LAST_TAG_EN   = 16;
	localparam int LAST_TAG_SEC  = 17;
	localparam int LAST_INST     = 18;

	// Entry word covers entry bits [143:112]
	localparam int ENTRY_BASE    = 112;
	localparam int IDO_LSB       = 114 - ENTRY_BASE; // inst_data_override [115:114]
	localparam int IMPL_LSB      = 116 - ENTRY_BASE; // Implementation bits [127:116]
	localparam int IMPL_WIDTH    = 12;
	localparam int TAG_LSB       = 128 - ENTRY_BASE; // stage2_vm_tag [143:128]
	localparam int TAG_WIDTH     = 16;
	localparam int TAG_NARROW    = 8;                // Narrow tag width

	// Override field encodings
	localparam logic [1:0] IDO_PASS      = 2'h0;
	localparam logic [1:0] IDO_PASS_ALT  = 2'h1;
	localparam logic [1:0] IDO_DATA      = 2'h2;
	localparam logic [1:0] IDO_INST      = 2'h3;

	// Stream privilege world encodings
	typedef enum logic [1:0] {
		SAV_WORLD_NS_KERNEL = 2'b00,
		SAV_WORLD_NS_HYP    = 2'b01,
		SAV_WORLD_SECURE    = 2'b10,
		SAV_WORLD_OTHER     = 2'b11
	} sav_world_e;

	localparam logic [15:0] COUNT_RESET = 16'h0000;

endpackage

`default_nettype wire

// ==== core/sav_inst_attr.sv ====
/*
 * Resolves the instruction/data attribute of one transaction from the
 * incoming attribute and the entry's override field.
 * Assumes the feature bit is a stable register value; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module sav_inst_attr (
	// Feature
	input  wire logic       attr_override_supported,
	// Transaction
	input  wire logic       txn_write,
	input  wire logic       txn_inst,
	input  wire logic [1:0] inst_data_override,
	// Result
	output logic            res_inst
);

	// Override decode; writes are always data
	always_comb begin
		res_inst = txn_inst;
		if (txn_write) begin
			res_inst = 1'b0;
		end else if (!attr_override_supported) begin
			res_inst = txn_inst;
		end else begin
			case (inst_data_override)
				sav_pkg::IDO_PASS:     res_inst = txn_inst;
				sav_pkg::IDO_PASS_ALT: res_inst = txn_inst;   // Same as pass
				sav_pkg::IDO_DATA:     res_inst = 1'b0;
				sav_pkg::IDO_INST:     res_inst = 1'b1;
				default:               res_inst = txn_inst;
			endcase
		end
	end

endmodule

`default_nettype wire

// ==== core/sav_vm_tag.sv ====
/*
 * Chooses the VM tag for one transaction, or no tag, from the entry's tag
 * field, its security state, world and stage enables.
 * Assumes feature bits are stable register values; purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

module sav_vm_tag (
	// Features
	input  wire logic        stage2_present,
	input  wire logic        secure_stage2_present,
	input  wire logic        wide_vm_tag_support,
	input  wire logic        embedded_variant,
	// Entry
	input  wire logic        entry_secure,
	input  wire logic [1:0]  stream_privilege_world,
	input  wire logic [1:0]  stage_en,
	input  wire logic [15:0] stage2_vm_tag,
	// Result
	output logic [15:0]      eff_tag,
	output logic             tag_en,
	output logic [15:0]      tag,
	output logic             tag_secure,
	output logic             tag_illegal
);

	logic s2_here; // Stage 2 exists in the entry's security state

	// Embedded parts may read the field, or its top half, as zero
	always_comb begin
		eff_tag = stage2_vm_tag;
		if (embedded_variant && !stage2_present) begin
			eff_tag = 16'h0000;
		end else if (embedded_variant && !wide_vm_tag_support) begin
			eff_tag = {8'h00, stage2_vm_tag[7:0]};
		end
	end

	// Tag selection per security state
	always_comb begin
		s2_here    = entry_secure ? secure_stage2_present : stage2_present;
		tag_en     = 1'b0;
		tag        = 16'h0000;
		tag_secure = entry_secure;                              // Separate namespaces
		if (!s2_here || stage_en == 2'b00) begin
			tag_en = 1'b0;
		end else if (!entry_secure) begin
			if (stream_privilege_world == sav_pkg::SAV_WORLD_NS_KERNEL) begin
				tag_en = 1'b1;
				tag    = eff_tag;
			end
		end else if (stream_privilege_world == sav_pkg::SAV_WORLD_SECURE) begin
			tag_en = 1'b1;
			if (stage_en[1]) begin
				tag = eff_tag;                                  // Includes nested
			end else begin
				tag = 16'h0000;                                 // Stage 1 only
			end
		end
		// Narrow tags with top bits set are illegal only when the field is used
		tag_illegal = tag_en && !wide_vm_tag_support && tag[15:8] != 8'h00;
	end

endmodule

`default_nettype wire

// ==== verification/sav_client_model.sv ====
/*
 * Client device model: issues one transaction per request from the bench.
 * Assumes requests arrive by non-blocking assignment after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module sav_client_model (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Request from the bench
	input  wire logic        req_valid,
	input  wire logic        req_write,
	input  wire logic        req_inst,
	input  wire logic [31:0] req_word,
	input  wire logic        req_secure,
	input  wire logic [1:0]  req_world,
	input  wire logic [1:0]  req_stage_en,
	// Transaction towards the block
	output logic             txn_valid,
	output logic             txn_write,
	output logic             txn_inst,
	output logic [31:0]      txn_entry_word,
	output logic             txn_entry_secure,
	output logic [1:0]       txn_world,
	output logic [1:0]       txn_stage_en
);
	// Launch a transaction; between them the fields toggle, so a stale value is caught
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txn_valid        <= 1'b0;
			txn_write        <= 1'b0;
			txn_inst         <= 1'b0;
			txn_entry_word   <= 32'h0;
			txn_entry_secure <= 1'b0;
			txn_world        <= 2'h0;
			txn_stage_en     <= 2'h0;
		end else if (req_valid) begin
			// Upper tag byte passed as asked, even where illegal
			txn_valid        <= 1'b1;
			txn_write        <= req_write;
			txn_inst         <= req_inst;
			txn_entry_word   <= req_word;
			txn_entry_secure <= req_secure;
			txn_world        <= req_world;
			txn_stage_en     <= req_stage_en;
		end else begin
			// Fields carry no meaning outside a transaction
			txn_valid        <= 1'b0;
			txn_write        <= ~txn_write;
			txn_inst         <= ~txn_inst;
			txn_entry_word   <= ~txn_entry_word;
			txn_entry_secure <= ~txn_entry_secure;
			txn_world        <= ~txn_world;
			txn_stage_en     <= ~txn_stage_en;
		end
	end
endmodule

`default_nettype wire

// ==== verification/stream_attr_virtual_machine_tag_select_bench.sv ====
/*
 * Self-checking bench: AHB-Lite master, client model, result scoreboard.
 * Assumes the one-cycle result latency and register map of the block.
 */
`timescale 1ns/1ps
`default_nettype none

module stream_attr_virtual_machine_tag_select_bench;
	typedef struct packed {
		logic        inst;
		logic        ten;
		logic [15:0] tag;
		logic        sec;
		logic [11:0] impl;
		logic        ill;
	} sav_exp_s;

	logic hclk = 1'b0, hresetn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, hready;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp;
	logic rv = 1'b0, rw = 1'b0, ri = 1'b0, rs = 1'b0;
	logic [31:0] rword = 32'h0;
	logic [1:0] rwo = 2'h0, rse = 2'h0;
	// Drawn fields, kept so the note matches what the model is handed
	logic pick_w, pick_i, pick_s;
	logic [31:0] pick_word;
	logic [1:0] pick_wo, pick_se;
	logic t_v, t_w, t_i, t_s;
	logic [31:0] t_word;
	logic [1:0] t_wo, t_se;
	logic o_v, o_i, o_te, o_ts, o_ill;
	logic [15:0] o_tag;
	logic [11:0] o_impl;
	int fail_count = 0, tests_run = 0, cycles = 0, issued = 0;
	integer seed;
	sav_exp_s q[$];
	sav_exp_s last;
	logic ill_seen;

	// Clock at 250 MHz; the single slave's ready is the bus ready
	always #2 hclk = ~hclk;
	assign hready = hreadyout;

	sav_client_model cli_u (.hclk(hclk), .hresetn(hresetn), .req_valid(rv), .req_write(rw),
		.req_inst(ri), .req_word(rword), .req_secure(rs), .req_world(rwo),
		.req_stage_en(rse), .txn_valid(t_v), .txn_write(t_w), .txn_inst(t_i),
		.txn_entry_word(t_word), .txn_entry_secure(t_s), .txn_world(t_wo),
		.txn_stage_en(t_se));

	sav_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txn_valid(t_v),
		.txn_write(t_w), .txn_inst(t_i), .txn_entry_word(t_word), .txn_entry_secure(t_s),
		.txn_world(t_wo), .txn_stage_en(t_se), .out_valid(o_v), .out_inst(o_i),
		.out_tag_en(o_te), .out_tag(o_tag), .out_tag_secure(o_ts), .out_impl_cfg(o_impl),
		.out_illegal(o_ill));

	// One comparison, counted; a mismatch is reported at once
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// Single word transfer; waits on ready, read data taken at the data phase edge
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	// Reference result of one transaction under feature bits f
	function automatic sav_exp_s model(input logic [4:0] f, input logic w, input logic i,
		input logic [31:0] e, input logic s, input logic [1:0] wo, input logic [1:0] se);
		sav_exp_s r;
		logic [1:0] ido;
		logic use_tag;
		ido = e[3:2];
		r.inst = i;
		if (f[0] && ido == sav_pkg::IDO_DATA) r.inst = 1'b0;
		if (f[0] && ido == sav_pkg::IDO_INST) r.inst = 1'b1;
		if (w) r.inst = 1'b0;
		r.ten = (s ? f[3] : f[1]) && (se != 2'b00) &&
			(s ? wo == sav_pkg::SAV_WORLD_SECURE : wo == sav_pkg::SAV_WORLD_NS_KERNEL);
		use_tag = r.ten && !(s && se == 2'b01);
		r.tag = use_tag ? e[31:16] : 16'h0;
		if (f[4] && !f[2]) r.tag[15:8] = 8'h0;
		if (f[4] && !f[1]) r.tag = 16'h0;
		r.sec = s;
		r.impl = e[15:4];
		// Judged on the tag actually used, after any read-as-zero
		r.ill = !f[2] && r.tag[15:8] != 8'h0;
		return r;
	endfunction

	// Scoreboard: each result pulse takes the oldest note
	always @(posedge hclk) begin
		if (hresetn && o_v === 1'b1) begin
			if (q.size() == 0) begin
				chk("result without transaction", 32'h0, 32'h1);
			end else begin
				sav_exp_s e;
				e = q.pop_front();
				chk("inst", {31'h0, e.inst}, {31'h0, o_i});
				chk("tag_en", {31'h0, e.ten}, {31'h0, o_te});
				chk("tag", {16'h0, e.tag}, {16'h0, o_tag});
				chk("tag_secure", {31'h0, e.sec}, {31'h0, o_ts});
				chk("impl", {20'h0, e.impl}, {20'h0, o_impl});
				chk("illegal", {31'h0, e.ill}, {31'h0, o_ill});
			end
		end
	end

	// Hang guard
	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Feature sets: none, all, narrow without embedding, wide embedded, narrow embedded,
	// embedded without non-secure stage 2
	logic [4:0] cfgs [6] = '{5'h00, 5'h1f, 5'h0b, 5'h17, 5'h1b, 5'h19};

	initial begin
		seed = 32'h8c53;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, sav_pkg::OFF_FEATURE, 32'h0);
		chk("feature reset", 32'h0, rd);
		ahb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, rd);
		foreach (cfgs[c]) begin
			ahb(1'b1, sav_pkg::OFF_FEATURE, {27'h0, cfgs[c]});
			ahb(1'b0, sav_pkg::OFF_FEATURE, 32'h0);
			chk("feature", {27'h0, cfgs[c]}, rd);
			ahb(1'b1, sav_pkg::OFF_ILLEGAL, 32'h1);
			ill_seen = 1'b0;
			// Random traffic, mostly back to back
			repeat (60) begin
				@(posedge hclk);
				if ($random(seed) % 4 == 0) begin
					rv <= 1'b0;
				end else begin
					pick_w    = $random(seed);
					pick_i    = $random(seed);
					pick_word = $random(seed);
					pick_s    = $random(seed);
					pick_wo   = $random(seed);
					pick_se   = $random(seed);
					// Requests change only by non-blocking assignment after the edge
					rw    <= pick_w;
					ri    <= pick_i;
					rword <= pick_word;
					rs    <= pick_s;
					rwo   <= pick_wo;
					rse   <= pick_se;
					rv    <= 1'b1;
					last = model(cfgs[c], pick_w, pick_i, pick_word, pick_s, pick_wo, pick_se);
					ill_seen |= last.ill;
					q.push_back(last);
					issued++;
				end
			end
			@(posedge hclk);
			rv <= 1'b0;
			repeat (4) @(posedge hclk);
			ahb(1'b0, sav_pkg::OFF_LAST, 32'h0);
			chk("last", {13'h0, last.inst, last.sec, last.ten, last.tag}, rd);
			ahb(1'b0, sav_pkg::OFF_ILLEGAL, 32'h0);
			chk("illegal flag", {31'h0, ill_seen}, rd);
			$display("feature set %h done", cfgs[c]);
		end
		ahb(1'b0, sav_pkg::OFF_COUNT, 32'h0);
		chk("count", {16'h0, issued[15:0]}, rd);
		chk("queue drained", 32'h0, q.size());
		final_report();
	end
endmodule

`default_nettype wire
